// [logic/jlm_link_mapper.sv]
// jlm_link_mapper: transmit mapping, coding and link start-up plus
// receive decode, alignment, frame buffering and reformatting
// assumes inputs synchronous to core_clk; serdes lanes are 20-bit words
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module jlm_link_mapper
    import jlm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    input  wire logic [31:0]       tx_iq0,
    input  wire logic [31:0]       tx_iq1,
    output logic                   tx_take,
    output logic      [3:0][19:0]  tx_lane,
    input  wire logic [3:0][19:0]  rx_lane,
    input  wire logic [1:0]        link_sync_status_in,
    output logic      [1:0]        link_sync_request_out,
    input  wire logic              sysref,
    input  wire logic              downlink_frame_sync,
    output var jlm_rx_out_t        rx_out,
    output logic                   link_event
);

    jlm_state_t s;       // all state
    jlm_state_t next_s;  // next value
    logic [3:0] lane_err; // data word with coding error
    logic [1:0] rel;      // all lanes of link aligned

    // *************************************************
    // coding helpers
    // *************************************************
    // odd parity symbol: one flipped bit shows as an error
    function automatic logic [9:0] enc(input logic k, input logic [7:0] o);
        return {k, ~^{k, o}, o};
    endfunction : enc

    // self-synchronous 1+x14+x15, msb first; de selects descramble
    function automatic logic [30:0] scr(input logic [14:0] st_in,
                                        input logic [15:0] din,
                                        input logic de);
        logic [14:0] st;
        logic [15:0] q;
        logic        b;
        st = st_in;
        q  = 16'h0000;
        b  = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            b    = din[i] ^ st[14] ^ st[13];
            q[i] = b;
            st   = {st[13:0], de ? din[i] : b};
        end
        return {st, q};
    endfunction : scr

    assign reg_rdata             = s.rdata;
    assign tx_lane               = s.tx_sym;
    assign link_sync_request_out = s.sreq;
    assign rx_out                = s.rxo;
    assign link_event            = s.evt;
    assign tx_take               = (s.ph == 2'h0);

    // *************************************************
    // next state
    // *************************************************
    always_comb begin
        jlm_mode_t   mode;
        logic [1:0]  plast, ssel, cur_st;
        logic [63:0] cur;
        logic [31:0] sm;
        logic [15:0] mw;
        logic [7:0]  o0, o1;
        logic [1:0]  kk;
        logic [19:0] sym, rin;
        logic [30:0] sr;
        logic [3:0][15:0] w;
        jlm_word_t   wd, ow;
        logic        ev, mfend, e, issync, l;
        logic [1:0]  cgs_any, mis, lerr;
        mode    = jlm_mode_t'(s.ctrl[C_MODE+:3]);
        plast   = 2'h0;
        ssel    = s.ctrl[C_SSEL+:2];
        cur_st  = 2'h0;
        cur     = 64'h0;
        sm      = 32'h0;
        mw      = 16'h0;
        o0      = 8'h00;
        o1      = 8'h00;
        kk      = 2'h0;
        sym     = 20'h0;
        rin     = 20'h0;
        sr      = 31'h0;
        w       = '0;
        wd      = '0;
        ow      = '0;
        ev      = 1'b0;
        e       = 1'b0;
        issync  = 1'b0;
        l       = 1'b0;
        cgs_any = 2'h0;
        mis     = 2'h0;
        lerr    = 2'h0;
        rel     = 2'h3;
        lane_err = 4'h0;
        mfend   = (s.mf_cnt == MF_LAST);
        next_s  = s;
        next_s.swp   = 1'b0;
        next_s.rdata = 16'h0000;

        // register writes; the software sync is a one-cycle pulse
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL:   next_s.ctrl = reg_wdata;
                REG_LMAP:   next_s.lmap = reg_wdata;
                REG_SWSYNC: next_s.swp  = 1'b1;
                REG_ERR0:   next_s.ecnt[0] = 16'h0000;
                REG_ERR1:   next_s.ecnt[1] = 16'h0000;
                default:    next_s.swp  = 1'b0;
            endcase
        end

        // event source, rising edge realigns frame/multiframe count
        case (ssel)
            2'h1:    ev = downlink_frame_sync;
            2'h2:    ev = s.swp;
            default: ev = sysref;
        endcase
        next_s.evd    = ev;
        next_s.mf_cnt = (ev && !s.evd) ? 4'h0 : s.mf_cnt + 4'h1;

        // transfer phase: 1, 2 or 4 clocks per IQ transfer
        if (mode == JLM_IQ) plast = 2'h1;
        if (mode == JLM_TDM) plast = 2'h3;
        next_s.ph  = (s.ph >= plast) ? 2'h0 : s.ph + 2'h1;
        next_s.mph = s.ph;
        cur = (s.ph == 2'h0) ? {tx_iq1, tx_iq0} : s.hold;
        if (s.ph == 2'h0) next_s.hold = {tx_iq1, tx_iq0};

        // *************************************************
        // transmit link state per link
        // *************************************************
        for (int j = 0; j < 2; j++) begin
            next_s.syn_a[j] = link_sync_status_in[j];
            next_s.syn_b[j] = s.syn_a[j];
            // short low pulses report errors; only a long low restarts
            next_s.slow[j] = s.syn_b[j] ? 3'h0 :
                             (s.slow[j] == LOST_LOW) ? LOST_LOW : s.slow[j] + 3'h1;
            case (s.tx_st[j])
                JLM_TX_CGS: begin
                    // hold sync chars to the multiframe boundary
                    if (s.syn_b[j] && mfend) begin
                        next_s.tx_st[j] = JLM_TX_ILA;
                        next_s.ila[j]   = 2'h0;
                    end
                end
                JLM_TX_ILA: begin
                    if (s.slow[j] == LOST_LOW) next_s.tx_st[j] = JLM_TX_CGS;
                    else if (mfend) begin
                        if (s.ila[j] == ILA_LAST) next_s.tx_st[j] = JLM_TX_DATA;
                        next_s.ila[j] = s.ila[j] + 2'h1;
                    end
                end
                JLM_TX_DATA: if (s.slow[j] == LOST_LOW) next_s.tx_st[j] = JLM_TX_CGS;
                default: next_s.tx_st[j] = JLM_TX_CGS;
            endcase
        end

        next_s.prbs = {s.prbs[5:0], s.prbs[6] ^ s.prbs[5]};

        // *************************************************
        // transmit lanes: map, scramble, align, encode
        // *************************************************
        for (int k = 0; k < 4; k++) begin
            sm = k[0] ? cur[63:32] : cur[31:0];
            case (mode)
                JLM_SPLIT: mw = cur[{k[1], ~k[0]}*16+:16];
                JLM_IQ:    mw = s.ph[0] ? sm[15:0] : sm[31:16];
                JLM_TDM:   mw = s.ph[0] ? cur[{s.ph[1], 1'b0}*16+:16]
                                        : cur[{s.ph[1], 1'b1}*16+:16];
                JLM_IONLY: mw = sm[31:16];
                JLM_QONLY: mw = sm[15:0];
                default:   mw = 16'h0000;
            endcase
            next_s.map[k] = mw;
            l  = s.lmap[k];
            kk = 2'h0;
            case (s.tx_st[l])
                JLM_TX_ILA: begin
                    // start marker, then counts; multiframe end marked
                    o0 = (s.mf_cnt == 4'h0) ? K_START : {4'h0, s.mf_cnt};
                    o1 = mfend ? K_MF : 8'(k);
                    kk = {s.mf_cnt == 4'h0, mfend};
                end
                JLM_TX_DATA: begin
                    sr = scr(s.scr[k], s.map[k], 1'b0);
                    next_s.scr[k] = sr[30:16];
                    if (!s.ctrl[C_SCR]) sr[15:0] = s.map[k];
                    o0 = sr[15:8];
                    o1 = sr[7:0];
                    next_s.tprev[k] = sr[7:0];
                    // repeat of last octet becomes a marker; rx restores it
                    if (sr[7:0] == s.tprev[k]) begin
                        o1 = mfend ? K_MF : K_FR;
                        kk = 2'h1;
                    end
                end
                default: begin
                    o0 = K_SYNC;
                    o1 = K_SYNC;
                    kk = 2'h3;
                end
            endcase
            sym = {enc(kk[0], o1), enc(kk[1], o0)};
            case (s.lmap[L_TEST+:2])
                2'h1:    sym = {2{enc(1'b1, K_SYNC)}};
                2'h2:    sym = {s.prbs[5:0], s.prbs, s.prbs};
                default: sym = sym;
            endcase
            next_s.tx_sym[k] = sym;
        end

        // *************************************************
        // receive lanes: decode, lock, deskew, frame buffer
        // *************************************************
        for (int k = 0; k < 4; k++)
            if (s.rx_st[k] != JLM_RX_ALN) rel[s.lmap[k]] = 1'b0;
        for (int k = 0; k < 4; k++) begin
            l   = s.lmap[k];
            rin = s.ctrl[C_LPBK+k] ? s.tx_sym[k] : rx_lane[k];
            e   = !(^rin[9:0]) || !(^rin[19:10]);
            wd  = {e, rin[9], rin[19], rin[7:0], rin[17:10]};
            issync = !e && wd.k == 2'h3 && wd.d == {K_SYNC, K_SYNC};
            next_s.eb[k] = {s.eb[k][2:0], wd};
            ow = s.eb[k][s.dly[k]];
            case (s.rx_st[k])
                JLM_RX_CGS: begin
                    next_s.cgs[k] = issync ? s.cgs[k] + 3'h1 : 3'h0;
                    next_s.dly[k] = 2'h0;
                    next_s.mfc[k] = 3'h0;
                    if (issync && s.cgs[k] == CGS_NEED - 3'h1) next_s.rx_st[k] = JLM_RX_WAIT;
                end
                JLM_RX_WAIT: begin
                    if (wd.k[1] && wd.d[15:8] == K_START && !e) next_s.rx_st[k] = JLM_RX_ALN;
                    next_s.dly[k] = 2'h0;
                end
                JLM_RX_ALN: begin
                    // early lanes age their start word until the link is all in
                    if (!rel[l] && s.dly[k] != 2'h3) next_s.dly[k] = s.dly[k] + 2'h1;
                    if (rel[l]) begin
                        if ((ow.k[1] && ow.d[15:8] != K_START) || ow.d == {K_SYNC, K_SYNC}) begin
                            next_s.rx_st[k] = JLM_RX_CGS;
                            mis[l] = 1'b1;
                        end else if (s.mfc[k] != ILA_MKS) begin
                            if (ow.k[0] && ow.d[7:0] == K_MF) next_s.mfc[k] = s.mfc[k] + 3'h1;
                        end else begin
                            o1 = (ow.k[0] && (ow.d[7:0] == K_FR || ow.d[7:0] == K_MF))
                                 ? s.rprev[k] : ow.d[7:0];
                            next_s.rprev[k] = o1;
                            sr = scr(s.dscr[k], {ow.d[15:8], o1}, 1'b1);
                            next_s.dscr[k] = sr[30:16];
                            if (!s.ctrl[C_SCR]) sr[15:0] = {ow.d[15:8], o1};
                            lane_err[k] = ow.e;
                            if (!ow.e) next_s.fbuf[k] = sr[15:0];
                        end
                    end
                end
                default: next_s.rx_st[k] = JLM_RX_CGS;
            endcase
            if (s.rx_st[k] == JLM_RX_CGS) cgs_any[l] = 1'b1;
            if (lane_err[k]) lerr[l] = 1'b1;
        end

        // *************************************************
        // link requests, error statistics, events
        // *************************************************
        for (int j = 0; j < 2; j++) begin
            next_s.errlow[j] = lerr[j] ? ERR_LOW :
                               (s.errlow[j] != 2'h0) ? s.errlow[j] - 2'h1 : 2'h0;
            // low while any lane hunts, on misalign and per error
            next_s.sreq[j] = !cgs_any[j] && !mis[j] && next_s.errlow[j] == 2'h0;
            if (lerr[j]) next_s.ecnt[j] = next_s.ecnt[j] + 16'h0001;
        end
        next_s.evt = |lerr || |mis;

        // *************************************************
        // receive formatter
        // *************************************************
        for (int k = 0; k < 4; k++)
            w[k] = s.ctrl[C_MAPLB] ? s.map[k] : s.fbuf[k];
        next_s.rxo.vld = 1'b1;
        if (mode == JLM_IQ || mode == JLM_TDM) begin
            // I then Q on one lane; emit on the Q clock
            if (!s.mph[0]) begin
                next_s.ri = w[0];
                next_s.fi = w[2];
                next_s.rxo.vld = 1'b0;
            end else begin
                next_s.rxo.rx = {s.ri, w[0]};
                next_s.rxo.fb = {s.fi, w[2]};
            end
        end else begin
            next_s.rxo.rx = {w[0], w[1]};
            next_s.rxo.fb = {w[2], w[3]};
        end

        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: next_s.rdata = s.ctrl;
                REG_LMAP: next_s.rdata = s.lmap;
                REG_STAT: begin
                    for (int k = 0; k < 4; k++) begin
                        next_s.rdata[8+k] = (s.rx_st[k] == JLM_RX_ALN);
                        next_s.rdata[4+k] = (s.rx_st[k] != JLM_RX_CGS);
                    end
                    for (int j = 0; j < 2; j++) begin
                        next_s.rdata[2+j] = (s.tx_st[j] == JLM_TX_DATA);
                        next_s.rdata[j]   = s.syn_b[j];
                    end
                end
                REG_ERR0: next_s.rdata = s.ecnt[0];
                REG_ERR1: next_s.rdata = s.ecnt[1];
                default:  next_s.rdata = 16'h0000;
            endcase
        end
    end

    // state register; link 1 owns lanes 2,3 after reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s      <= '0;
            s.ctrl <= CTRL_RST;
            s.lmap <= LMAP_RST;
            s.prbs <= PRBS_RST;
        end else begin
            s <= next_s;
        end
    end

    // *************************************************
    // checks
    // *************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_sync_two_flop: assert property ($past(rst_b, 2) |-> s.syn_b == $past(link_sync_status_in, 2))
        else $error("sync input not delayed two stages");
    a_cgs_chars: assert property ((s.tx_st[0] == JLM_TX_CGS && !s.lmap[0] && s.lmap[5:4] == 2'h0)
        |=> tx_lane[0] == {2{enc(1'b1, K_SYNC)}}) else $error("lane 0 not sending sync chars");
    a_ila_at_mf: assert property ((s.tx_st[0] == JLM_TX_ILA && $past(s.tx_st[0]) == JLM_TX_CGS)
        |-> $past(s.mf_cnt) == MF_LAST) else $error("alignment sequence off boundary");
    a_req_low_hunt: assert property ((s.rx_st[0] == JLM_RX_CGS && !s.lmap[0])
        |=> !link_sync_request_out[0]) else $error("request high while lane hunts");
    a_err_low_pulse: assert property ((lane_err[0] && !s.lmap[0])
        |=> !link_sync_request_out[0] [*2]) else $error("error not reported on request");
    a_take_tdm: assert property ((tx_take && s.ctrl[8:6] == JLM_TDM && s.ph == 2'h0)
        |=> !tx_take [*3] ##1 tx_take) else $error("tdm transfer not four clocks");
    a_event_err: assert property ((|lane_err) |=> link_event)
        else $error("no event on lane error");
    a_frame_hold: assert property (lane_err[0] |=> s.fbuf[0] == $past(s.fbuf[0]))
        else $error("errored frame reached buffer");

endmodule : jlm_link_mapper

`default_nettype wire

// [logic/jlm_pkg.sv]
// jlm_pkg: constants, types and carriers of the four-lane link mapper
// assumes one 25 MHz core clock and a plain word-wide register port
`default_nettype none

package jlm_pkg;

    // *************************************************
    // register map and fields
    // *************************************************
    localparam logic [3:0]  REG_CTRL   = 4'h0;     // mode, scrambler, loopbacks
    localparam logic [3:0]  REG_LMAP   = 4'h1;     // lane to link, test pattern
    localparam logic [3:0]  REG_SWSYNC = 4'h2;     // write issues processor sync
    localparam logic [3:0]  REG_STAT   = 4'h3;     // link and lane state
    localparam logic [3:0]  REG_ERR0   = 4'h4;     // link 0 error count
    localparam logic [3:0]  REG_ERR1   = 4'h5;     // link 1 error count
    localparam logic [15:0] CTRL_RST   = 16'h0001; // scrambler on
    localparam logic [15:0] LMAP_RST   = 16'h000C; // lanes 2,3 on link 1
    localparam int          C_SCR      = 0;        // scrambler enable
    localparam int          C_LPBK     = 1;        // four lane loopback bits
    localparam int          C_MAPLB    = 5;        // mapping loopback
    localparam int          C_MODE     = 6;        // three mode bits
    localparam int          C_SSEL     = 9;        // two sync select bits
    localparam int          L_TEST     = 4;        // two test pattern bits

    // *************************************************
    // link characters and counts
    // *************************************************
    localparam logic [7:0] K_SYNC   = 8'hBC;  // sync character
    localparam logic [7:0] K_START  = 8'h1C;  // alignment sequence start
    localparam logic [7:0] K_MF     = 8'h7C;  // multiframe alignment
    localparam logic [7:0] K_FR     = 8'hFC;  // frame alignment
    localparam logic [3:0] MF_LAST  = 4'hF;   // last frame of multiframe
    localparam logic [1:0] ILA_LAST = 2'h3;   // four multiframes of sequence
    localparam logic [2:0] ILA_MKS  = 3'h4;   // markers before data
    localparam logic [2:0] CGS_NEED = 3'h4;   // sync words to lock
    localparam logic [1:0] ERR_LOW  = 2'h2;   // request low per error
    localparam logic [2:0] LOST_LOW = 3'h4;   // low cycles meaning resync
    localparam logic [6:0] PRBS_RST = 7'h7F;  // pattern seed

    typedef enum logic [2:0] {
        JLM_SPLIT = 3'b000, JLM_IQ = 3'b001, JLM_TDM = 3'b010,
        JLM_IONLY = 3'b011, JLM_QONLY = 3'b100
    } jlm_mode_t;
    typedef enum logic [1:0] {
        JLM_TX_CGS = 2'b00, JLM_TX_ILA = 2'b01, JLM_TX_DATA = 2'b10
    } jlm_tx_t;
    typedef enum logic [1:0] {
        JLM_RX_CGS = 2'b00, JLM_RX_WAIT = 2'b01, JLM_RX_ALN = 2'b10
    } jlm_rx_t;

    typedef struct packed {
        logic        e;  // coding error
        logic [1:0]  k;  // control flags, octet 0 high
        logic [15:0] d;  // octet 0 in high byte
    } jlm_word_t;

    typedef struct packed {
        logic        vld;
        logic [31:0] rx;  // receive I,Q
        logic [31:0] fb;  // feedback I,Q
    } jlm_rx_out_t;

    typedef struct packed {
        logic [15:0]            ctrl, lmap, rdata;
        logic                   swp, evd, evt;
        logic [3:0]             mf_cnt;
        logic [1:0]             ph, mph, syn_a, syn_b, sreq;
        logic [63:0]            hold;
        logic [1:0][2:0]        slow;
        jlm_tx_t [1:0]          tx_st;
        logic [1:0][1:0]        ila, errlow;
        logic [1:0][15:0]       ecnt;
        logic [3:0][15:0]       map, fbuf;
        logic [3:0][7:0]        tprev, rprev;
        logic [3:0][14:0]       scr, dscr;
        logic [3:0][19:0]       tx_sym;
        logic [6:0]             prbs;
        jlm_rx_t [3:0]          rx_st;
        logic [3:0][2:0]        cgs, mfc;
        jlm_word_t [3:0][3:0]   eb;
        logic [3:0][1:0]        dly;
        logic [15:0]            ri, fi;
        jlm_rx_out_t            rxo;
    } jlm_state_t;

endpackage : jlm_pkg

`default_nettype wire

// [verif/jlm_far_end.sv]
// jlm_far_end: far-end transceiver model on the four serdes lanes
// assumes the design's parity symbol code and one shared core_clk
`timescale 1ns/100ps
`default_nettype none

module jlm_far_end
    import jlm_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             en,
    input  wire logic [3:0][19:0] tx_lane,
    output var  logic [3:0][19:0] rx_lane,
    output logic      [1:0]       sync_in
);
    // *****************************
    // far-end link start-up
    // *****************************
    localparam logic [19:0] SW = {2{2'b11, K_SYNC}}; // sync word, k and parity set
    logic [1:0][2:0] seen;                           // sync words seen per link

    // synced once four sync words arrived; held while enabled
    assign sync_in = {seen[1] == 3'h4, seen[0] == 3'h4};

    // lanes idle with a pattern flipping each cycle, never stale data
    initial rx_lane = {4{20'h3C0F1}};
    always @(posedge core_clk) begin
        rx_lane <= en ? {4{SW}} : ~rx_lane;
        for (int i = 0; i < 2; i++) begin
            if (!en) begin
                seen[i] <= 3'h0;
            end else if (tx_lane[2*i] == SW && seen[i] != 3'h4) begin
                seen[i] <= seen[i] + 3'h1;
            end
        end
    end
endmodule : jlm_far_end

`default_nettype wire

// [verif/tb.sv]
// tb: register-driven checks of link start-up, modes and loopback
// assumes jlm_far_end stands on the serdes side
`timescale 1ns/100ps
`default_nettype none

module tb
    import jlm_pkg::*;
;
    logic             core_clk, rst_b, reg_wr, reg_rd, far_en;
    logic [3:0]       reg_addr;
    logic [15:0]      reg_wdata, reg_rdata;
    logic [31:0]      iq;        // counting stream keeps the mapper busy
    logic             tx_take;
    logic [3:0][19:0] tx_lane, rx_lane;
    logic [1:0]       sync_in, sync_out;
    jlm_rx_out_t      rx_o;      // formatter output, watched under mapping loopback
    int               bad_count, check_count, cyc, n;
    localparam logic [19:0] SW = {2{2'b11, K_SYNC}};
    localparam int PER [5] = '{8, 4, 2, 8, 8}; // takes per 8 cycles by mode

    jlm_link_mapper dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_iq0(iq), .tx_iq1(~iq), .tx_take(tx_take), .tx_lane(tx_lane), .rx_lane(rx_lane),
        .link_sync_status_in(sync_in), .link_sync_request_out(sync_out), .sysref(1'b0),
        .downlink_frame_sync(1'b0), .rx_out(rx_o), .link_event());
    jlm_far_end far_u (.core_clk(core_clk), .en(far_en), .tx_lane(tx_lane),
        .rx_lane(rx_lane), .sync_in(sync_in));

    // *****************************
    // clock, tasks
    // *****************************
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk("register", 20'(exp), 20'(reg_rdata));
    endtask : rc

    task automatic reset_dut();
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask : reset_dut

    // *****************************
    // hang guard and stimulus
    // *****************************
    always @(posedge core_clk) begin
        iq <= iq + 32'h1;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, far_en, iq, cyc} = '0;
        bad_count = 0;
        check_count = 0;
        reset_dut();
        rc(REG_CTRL, CTRL_RST);
        rc(REG_LMAP, LMAP_RST);
        wr(4'hE, 16'hFFFF);
        rc(4'hE, 16'h0000);
        wr(REG_LMAP, 16'h0003);
        rc(REG_LMAP, 16'h0003);
        wr(REG_LMAP, LMAP_RST);
        repeat (8) @(negedge core_clk);
        chk("request", 20'h0, 20'(sync_out));
        chk("lane0", SW, tx_lane[0]);
        @(posedge core_clk);
        far_en <= 1'b1;
        repeat (12) @(negedge core_clk);
        chk("request", 20'h3, 20'(sync_out));
        n = 0;
        while (tx_lane[0][9:0] !== {2'b11, K_START} && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        chk("start", 20'({2'b11, K_START}), 20'(tx_lane[0][9:0]));
        wr(REG_LMAP, 16'h001C);
        repeat (3) @(negedge core_clk);
        chk("pattern", SW, tx_lane[1]);
        for (int m = 0; m < 5; m++) begin
            // land mode writes on the last clock of a transfer, never mid-transfer
            @(negedge core_clk iff tx_take === 1'b1);
            repeat (2) @(posedge core_clk);
            wr(REG_CTRL, (16'(m) << C_MODE) | CTRL_RST);
            repeat (8) @(negedge core_clk);
            n = 0;
            repeat (8) begin
                @(negedge core_clk);
                n += (tx_take === 1'b1) ? 1 : 0;
            end
            chk("takes", 20'(PER[m]), 20'(n));
        end
        // far end goes quiet: only the lane loopback can lock the lanes
        @(posedge core_clk);
        far_en <= 1'b0;
        reset_dut();
        wr(REG_CTRL, 16'h003F);
        repeat (12) @(negedge core_clk);
        chk("loopback", 20'h3, 20'(sync_out));
        // split mode: stream 0 I,Q returns two clocks after it was taken
        chk("maploop", 20'(iq - 32'h2), 20'(rx_o.rx));
        chk("maploop_fb", 20'(~(iq - 32'h2)), 20'(rx_o.fb));
        end_sim();
    end
endmodule : tb

`default_nettype wire
